// ---- logic/pbs_pkg.sv ----
// constants and types shared by the pipelined burst sram control logic
package pbs_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int PBS_ADDR_W = 17;
   localparam int PBS_LANES = 4;
   localparam int PBS_LANE_W = 8;
   localparam int PBS_DATA_W = PBS_LANES * PBS_LANE_W;
   localparam int PBS_BURST_W = 2;

   // ****************************************
   // burst counter and field positions
   // ****************************************
   localparam int PBS_BURST_LSB = 0;
   localparam int PBS_UPPER_LSB = PBS_BURST_LSB + PBS_BURST_W;
   localparam logic [PBS_BURST_W-1:0] PBS_BURST_STEP = 2'h1;
   localparam logic [PBS_BURST_W-1:0] PBS_CNT_RST = 2'h0;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [PBS_ADDR_W-1:0] PBS_ADDR_RST = 17'h00000;
   localparam logic [PBS_DATA_W-1:0] PBS_DATA_RST = 32'h00000000;
   localparam logic [PBS_LANES-1:0] PBS_LANES_NONE = 4'h0;

   // ****************************************
   // burst state
   // ****************************************
   typedef enum logic [1:0] {
      PBS_ST_DESEL = 2'h0,
      PBS_ST_ACTIVE = 2'h1
   } pbs_state_e;

endpackage

// ---- logic/pbs_sram_ctrl.sv ----
// control logic of a pipelined synchronous burst sram with single-cycle deselect
//
// Overview of operation
// - burst order high: step addresses invert bit 0, then bit 1, then both
// - burst order low: two low address bits count up by one, wrapping
// - selected only when both low enables low and high enable high
// - deselect on ctrl strobe with first enable off, or either strobe with first enable on while unselected
// - once deselected, stay idle with bus released until a new begin burst
// - selected with proc strobe low: load address, read burst, writes ignored
// - selected, proc strobe high, ctrl strobe low: load address, read or write
// - no new burst and step input low: advance the burst counter
// - no new burst and step input high: keep the current burst address
// - continue or suspend cycles write when write request active, per edge
// - write request: global write low, or gate low with any lane low
// - global write low writes every byte lane
// - global high, gate low: write only lanes whose enable is low
// - read when global and gate high, or global and all lanes high
// - read right after write returns new data; deselect releases the bus
// - active while sleep input low, sleep state while it is high
// - inputs and read data registered; read data one clock after address
// - every synchronous input sampled only on the rising clock edge
module pbs_sram_ctrl
   import pbs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic [PBS_ADDR_W-1:0] addr_i,
   input wire logic chip_select1_n_i,
   input wire logic chip_select_hi_i,
   input wire logic chip_select2_n_i,
   input wire logic proc_addr_strobe_n_i,
   input wire logic ctrl_addr_strobe_n_i,
   input wire logic burst_step_n_i,
   input wire logic all_bytes_write_n_i,
   input wire logic byte_write_gate_n_i,
   input wire logic [PBS_LANES-1:0] lane_write_n_i,
   input wire logic burst_order_i,
   input wire logic sleep_request_i,
   input wire logic out_enable_n_i,
   input wire logic [PBS_DATA_W-1:0] data_i,
   input wire logic [PBS_DATA_W-1:0] mem_rd_data_i,
   output logic [PBS_DATA_W-1:0] data_o,
   output logic data_oe_o,
   output logic [PBS_ADDR_W-1:0] mem_addr_o,
   output logic mem_rd_o,
   output logic [PBS_LANES-1:0] mem_wr_lane_o,
   output logic [PBS_DATA_W-1:0] mem_wr_data_o,
   output logic selected_o,
   output logic asleep_o
);

   // ****************************************
   // declarations
   // ****************************************
   pbs_state_e state_ff;
   pbs_state_e nxt_state;
   logic [PBS_BURST_W-1:0] base_ff;
   logic [PBS_BURST_W-1:0] nxt_base;
   logic [PBS_BURST_W-1:0] cnt_ff;
   logic [PBS_BURST_W-1:0] nxt_cnt;
   logic [PBS_ADDR_W-1:PBS_UPPER_LSB] upper_ff;
   logic [PBS_ADDR_W-1:PBS_UPPER_LSB] nxt_upper;
   logic [PBS_BURST_W-1:0] nxt_low;
   logic nxt_rd;
   logic [PBS_LANES-1:0] nxt_lanes;
   logic rd_valid_ff;
   logic sel_w;
   logic begin_proc_w;
   logic begin_ctrl_w;
   logic desel_w;
   logic cont_w;
   logic act_w;
   logic burst_on_w;
   logic wr_req_w;
   logic [PBS_LANES-1:0] lane_wr_w;

   // ****************************************
   // cycle decode
   // ****************************************
   // all decode works on the values present at the rising edge
   assign act_w = clk_en_i & ~sleep_request_i;
   assign sel_w = ~chip_select1_n_i & chip_select_hi_i & ~chip_select2_n_i;
   // proc strobe is only honoured while the first enable is low
   assign begin_proc_w = ~proc_addr_strobe_n_i & sel_w;
   assign begin_ctrl_w = proc_addr_strobe_n_i & ~ctrl_addr_strobe_n_i & sel_w;
   // deselect cases
   assign desel_w = (chip_select1_n_i & ~ctrl_addr_strobe_n_i)
      | (~chip_select1_n_i & ~sel_w & (~proc_addr_strobe_n_i | ~ctrl_addr_strobe_n_i));
   // a deselect needs no address, so addr_i is ignored in that cycle
   // everything else is a continue or suspend cycle
   assign cont_w = ~begin_proc_w & ~begin_ctrl_w & ~desel_w;
   // continue cycles touch the array only inside a burst
   assign burst_on_w = cont_w & (state_ff == PBS_ST_ACTIVE);

   // ****************************************
   // write enable decode
   // ****************************************
   // one lane per byte; global write overrides the gate and lanes
   // lane i of the strobe covers data bits 8i+7 down to 8i
   genvar gi;
   generate
      for (gi = 0; gi < PBS_LANES; gi++) begin : g_lane
         assign lane_wr_w[gi] = ~all_bytes_write_n_i
            | (~byte_write_gate_n_i & ~lane_write_n_i[gi]);
      end
   endgenerate
   // a read whenever no lane ends up enabled
   assign wr_req_w = |lane_wr_w;

   // ****************************************
   // next burst address and access
   // ****************************************
   always_comb begin
      nxt_base = base_ff;
      nxt_upper = upper_ff;
      nxt_cnt = cnt_ff;
      nxt_state = state_ff;
      nxt_rd = 1'b0;
      nxt_lanes = PBS_LANES_NONE;
      if (begin_proc_w | begin_ctrl_w) begin
         nxt_base = addr_i[PBS_BURST_LSB +: PBS_BURST_W];
         nxt_upper = addr_i[PBS_ADDR_W-1:PBS_UPPER_LSB];
         nxt_cnt = PBS_CNT_RST;
         nxt_state = PBS_ST_ACTIVE;
      end else if (desel_w) begin
         nxt_state = PBS_ST_DESEL;
      end else if (burst_on_w && !burst_step_n_i) begin
         nxt_cnt = cnt_ff + PBS_BURST_STEP;
      end
      // a high step input leaves the count as it is
      if (begin_proc_w) begin
         nxt_rd = 1'b1; // write enables ignored here
      end else if (begin_ctrl_w | burst_on_w) begin
         // read or write is chosen again on every edge
         nxt_rd = ~wr_req_w;
         nxt_lanes = lane_wr_w;
      end
   end

   // burst order: interleave flips bits, linear adds
   // the order input is assumed static, so no resync of it is done
   assign nxt_low = burst_order_i ? (nxt_base ^ nxt_cnt) : (nxt_base + nxt_cnt);

   // ****************************************
   // burst state registers
   // ****************************************
   // sleep keeps the burst position so that operation resumes where it was
   // selected_o mirrors the state so a closed burst is visible outside
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= PBS_ST_DESEL;
         base_ff <= PBS_CNT_RST;
         cnt_ff <= PBS_CNT_RST;
         upper_ff <= PBS_ADDR_RST[PBS_ADDR_W-1:PBS_UPPER_LSB];
         selected_o <= 1'b0;
      end else if (act_w) begin
         state_ff <= nxt_state;
         base_ff <= nxt_base;
         cnt_ff <= nxt_cnt;
         upper_ff <= nxt_upper;
         selected_o <= (nxt_state == PBS_ST_ACTIVE);
      end
   end

   // ****************************************
   // array access registers
   // ****************************************
   // the array sees a registered address, so a write on one edge is stored
   // before a read on the next edge looks it up
   // sleep clears the strobes but keeps the address, so waking resumes the burst
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_addr_o <= PBS_ADDR_RST;
         mem_rd_o <= 1'b0;
         mem_wr_lane_o <= PBS_LANES_NONE;
         mem_wr_data_o <= PBS_DATA_RST;
      end else if (clk_en_i) begin
         if (sleep_request_i) begin
            mem_rd_o <= 1'b0;
            mem_wr_lane_o <= PBS_LANES_NONE;
         end else begin
            mem_addr_o <= {nxt_upper, nxt_low};
            mem_rd_o <= nxt_rd;
            mem_wr_lane_o <= nxt_lanes;
            mem_wr_data_o <= data_i;
         end
      end
   end

   // ****************************************
   // sleep flag
   // ****************************************
   // only reports the pin; the freeze itself lives in the state registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         asleep_o <= 1'b0;
      end else if (clk_en_i) begin
         asleep_o <= sleep_request_i;
      end
   end

   // ****************************************
   // output data pipeline
   // ****************************************
   // read data is latched one edge after the array access; a deselect or a
   // write drops the valid flag, so nothing stale reaches the bus
   // data_o keeps its last word, so only the valid flag may gate the bus
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_o <= PBS_DATA_RST;
         rd_valid_ff <= 1'b0;
      end else if (clk_en_i) begin
         rd_valid_ff <= mem_rd_o;
         if (mem_rd_o) begin
            data_o <= mem_rd_data_i;
         end
      end
   end

   // output enable acts without the clock, so this one output is gated
   // combinationally from a flop and the enable pin
   assign data_oe_o = rd_valid_ff & ~out_enable_n_i;

   // ****************************************
   // assertions
   // ****************************************
   // every check runs on the one rising edge; a reset aborts any open attempt
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   a_interleave_step: assert property (
      act_w && (begin_proc_w || begin_ctrl_w) && burst_order_i
      ##1 act_w && burst_on_w && !burst_step_n_i && burst_order_i
      |=> mem_addr_o[1:0] == ($past(addr_i[1:0], 2) ^ 2'h1))
      else $error("interleaved first step wrong");

   a_linear_step: assert property (
      act_w && (begin_proc_w || begin_ctrl_w) && !burst_order_i
      ##1 act_w && burst_on_w && !burst_step_n_i && !burst_order_i
      |=> mem_addr_o[1:0] == 2'($past(addr_i[1:0], 2) + 2'h1))
      else $error("linear first step wrong");

   a_upper_hold: assert property (
      act_w && burst_on_w ##0 $past(act_w) && $past(mem_rd_o | (|mem_wr_lane_o))
      |=> mem_addr_o[PBS_ADDR_W-1:2] == $past(mem_addr_o[PBS_ADDR_W-1:2]))
      else $error("upper address moved in burst");

   a_suspend_hold: assert property (
      act_w && burst_on_w ##1 act_w && burst_on_w && burst_step_n_i
      |=> mem_addr_o == $past(mem_addr_o))
      else $error("suspend changed the address");

   a_proc_read_load: assert property (
      act_w && begin_proc_w
      |=> mem_rd_o && mem_wr_lane_o == 4'h0 && mem_addr_o == $past(addr_i))
      else $error("proc strobe did not start a read");

   a_ctrl_write_load: assert property (
      act_w && begin_ctrl_w && !all_bytes_write_n_i
      |=> !mem_rd_o && mem_wr_lane_o == 4'hF && mem_wr_data_o == $past(data_i))
      else $error("ctrl strobe write wrong");

   a_lane_select: assert property (
      act_w && begin_ctrl_w && all_bytes_write_n_i && !byte_write_gate_n_i
      |=> mem_wr_lane_o == ~$past(lane_write_n_i) && mem_rd_o == $past(&lane_write_n_i))
      else $error("byte lane write wrong");

   a_deselect_idle: assert property (
      act_w && desel_w ##1 (act_w && cont_w) [*2]
      |=> !mem_rd_o && mem_wr_lane_o == 4'h0 ##1 !rd_valid_ff)
      else $error("deselected device accessed");

   a_select_decode: assert property (
      act_w && !proc_addr_strobe_n_i && !chip_select1_n_i
      && (chip_select2_n_i || !chip_select_hi_i)
      |=> !selected_o && !mem_rd_o)
      else $error("unselected device started a burst");

   a_read_latency: assert property (
      clk_en_i && mem_rd_o |=> rd_valid_ff && data_o == $past(mem_rd_data_i))
      else $error("read data not one clock later");

   a_sleep_quiet: assert property (
      clk_en_i && sleep_request_i
      |=> asleep_o && !mem_rd_o && mem_wr_lane_o == 4'h0 && $stable(mem_addr_o))
      else $error("access during sleep");

   a_bus_release: assert property (
      clk_en_i && !mem_rd_o |=> !data_oe_o)
      else $error("bus driven without a read");

   // continue and suspend cycles pick read or write afresh on each edge
   a_write_continue: assert property (
      act_w && burst_on_w && wr_req_w
      |=> !mem_rd_o && mem_wr_lane_o != 4'h0 && mem_wr_data_o == $past(data_i))
      else $error("burst write cycle wrong");

   // a low global write overrides gate and lanes in any write cycle
   a_global_all: assert property (
      act_w && (begin_ctrl_w || burst_on_w) && !all_bytes_write_n_i
      |=> mem_wr_lane_o == 4'hF && !mem_rd_o)
      else $error("global write missed a lane");

   // one low lane under a low gate is enough to make a write
   a_lane_request: assert property (
      act_w && (begin_ctrl_w || burst_on_w) && !byte_write_gate_n_i
      && !(&lane_write_n_i)
      |=> !mem_rd_o && mem_wr_lane_o != 4'h0)
      else $error("lane enable did not make a write");

   // with global high, gate high or gate low with no lane low leaves the cycle a read
   a_read_no_lane: assert property (
      act_w && (begin_ctrl_w || burst_on_w) && all_bytes_write_n_i
      && (byte_write_gate_n_i || (&lane_write_n_i))
      |=> mem_rd_o && mem_wr_lane_o == 4'h0)
      else $error("cycle without write enable did not read");

   // advance pulses must not reopen a closed burst; only a begin does
   a_stay_deselected: assert property (
      act_w && !selected_o && cont_w
      |=> !selected_o && !mem_rd_o && mem_wr_lane_o == 4'h0)
      else $error("deselected device woke without a begin");

   // the wrap from the last address back to the first is easy to break
   a_linear_wrap: assert property (
      act_w && burst_on_w && !burst_step_n_i && !burst_order_i
      |=> mem_addr_o[1:0] == 2'($past(mem_addr_o[1:0]) + 2'h1))
      else $error("linear step or wrap wrong");

   // main scenarios that the bench is expected to reach
   c_read_burst: cover property (
      act_w && begin_proc_w ##1 (act_w && burst_on_w && !burst_step_n_i) [*3]);
   c_write_burst: cover property (
      act_w && begin_ctrl_w && wr_req_w ##1 (act_w && burst_on_w && wr_req_w) [*3]);
   c_pass_through: cover property (
      act_w && begin_ctrl_w && wr_req_w ##1 act_w && begin_proc_w ##2 data_oe_o);
   c_deselect: cover property (rd_valid_ff ##0 act_w && desel_w ##2 !data_oe_o);
   c_sleep_resume: cover property (
      act_w && begin_proc_w ##1 sleep_request_i ##1 act_w && burst_on_w && !burst_step_n_i);

endmodule

// ---- verification/pbs_array_model.sv ----
// behavioural memory array seen by the burst sram control logic
module pbs_array_model
   import pbs_pkg::*;
(
   input wire logic clock_i,
   input wire logic [PBS_ADDR_W-1:0] mem_addr_i,
   input wire logic [PBS_LANES-1:0] mem_wr_lane_i,
   input wire logic [PBS_DATA_W-1:0] mem_wr_data_i,
   output logic [PBS_DATA_W-1:0] mem_rd_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [PBS_DATA_W-1:0] mem_ff [16];

   // small array: only the low four address bits select a word
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem_ff[i] = {28'hC0DE000, 4'(i)};
      end
   end

   // lane writes land on the edge after the strobe, like a real array
   always @(posedge clock_i) begin
      for (int l = 0; l < PBS_LANES; l++) begin
         if (mem_wr_lane_i[l]) begin
            mem_ff[mem_addr_i[3:0]][8*l +: 8] <= mem_wr_data_i[8*l +: 8];
         end
      end
   end

   assign mem_rd_data_o = mem_ff[mem_addr_i[3:0]];
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the burst sram control logic
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pbs_pkg::*;
   localparam logic [2:0] BEG_RD = 3'b011;
   localparam logic [2:0] BEG_WC = 3'b101;
   localparam logic [2:0] CONT = 3'b110;
   localparam logic [2:0] SUSP = 3'b111;
   localparam logic [5:0] RD_W = 6'h3F;
   localparam logic [5:0] GW_ALL = 6'h1F;
   logic clock_i, rst_n_i, clk_en_i, ps_n, ac_n, adv_n, gw_n, bwe_n, order, sleep, oe_n;
   logic [2:0] csel;
   logic [3:0] lanes, mem_wr_lane_o;
   logic [PBS_ADDR_W-1:0] addr_i, mem_addr_o;
   logic [PBS_DATA_W-1:0] data_i, data_o, rd_data, mem_wr_data_o;
   logic data_oe_o, mem_rd_o, selected_o, asleep_o;
   int err_count = 0;
   int num_checks = 0;

   // ****************************************
   // clock, design and array
   // ****************************************
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   pbs_sram_ctrl dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .addr_i(addr_i), .chip_select1_n_i(csel[2]), .chip_select_hi_i(csel[1]),
      .chip_select2_n_i(csel[0]), .proc_addr_strobe_n_i(ps_n),
      .ctrl_addr_strobe_n_i(ac_n), .burst_step_n_i(adv_n), .all_bytes_write_n_i(gw_n),
      .byte_write_gate_n_i(bwe_n), .lane_write_n_i(lanes), .burst_order_i(order),
      .sleep_request_i(sleep), .out_enable_n_i(oe_n), .data_i(data_i),
      .mem_rd_data_i(rd_data), .data_o(data_o), .data_oe_o(data_oe_o),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_lane_o(mem_wr_lane_o),
      .mem_wr_data_o(mem_wr_data_o), .selected_o(selected_o), .asleep_o(asleep_o));

   pbs_array_model mdl (.clock_i(clock_i), .mem_addr_i(mem_addr_o),
      .mem_wr_lane_i(mem_wr_lane_o), .mem_wr_data_i(mem_wr_data_o), .mem_rd_data_o(rd_data));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // applies one bus cycle after a falling edge and returns after the next one
   task automatic step(input logic [2:0] ctl, input logic [16:0] a, input logic [5:0] wr,
                       input logic [31:0] d);
      {ps_n, ac_n, adv_n} = ctl;
      addr_i = a;
      {gw_n, bwe_n, lanes} = wr;
      data_i = d;
      @(negedge clock_i);
   endtask

   // burst order only changes while reset holds the block out of operation
   task automatic do_reset(input logic ord);
      rst_n_i = 1'b0;
      order = ord;
      csel = 3'b010;
      repeat (4) @(negedge clock_i);
      rst_n_i = 1'b1;
   endtask

   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_read_burst(input logic ord);
      logic [16:0] a, prev;
      logic [1:0] k;
      do_reset(ord);
      a = 17'h10005;
      step(BEG_RD, a, 6'h00, 32'h0); // write enables low yet still a read
      chk(32'(mem_wr_lane_o), 32'h0, "proc begin wrote");
      prev = a;
      for (int i = 1; i < 5; i++) begin
         k = (i < 4) ? 2'(i) : 2'h3;
         step((i < 4) ? CONT : SUSP, 17'h1FFFF, RD_W, 32'h0);
         chk(32'(mem_addr_o), ord ? 32'({a[16:2], a[1:0] ^ k}) : 32'({a[16:2], a[1:0] + k}),
             "burst address");
         chk(32'({mem_rd_o, mem_wr_lane_o}), 32'h10, "read strobe");
         chk(data_o, {28'hC0DE000, prev[3:0]}, "read data");
         chk(32'(data_oe_o), 32'h1, "bus drive");
         prev = mem_addr_o;
      end
   endtask

   task automatic t_write_lanes;
      logic [5:0] wr [5] = '{6'h1F, 6'h2E, 6'h26, 6'h2F, 6'h3A};
      logic [3:0] exp [5] = '{4'hF, 4'h1, 4'h9, 4'h0, 4'h0};
      do_reset(1'b1);
      for (int i = 0; i < 5; i++) begin
         step(BEG_WC, 17'(8 + i), wr[i], 32'hA0 + i);
         chk(32'(mem_wr_lane_o), 32'(exp[i]), "lanes");
         chk(32'(mem_rd_o), 32'(exp[i] == 4'h0), "read when no lane");
         chk(32'(mem_addr_o), 32'(8 + i), "begin address");
      end
      step(SUSP, 17'h0, GW_ALL, 32'h77);
      chk(32'({mem_addr_o, mem_wr_lane_o}), 32'h0CF, "suspend write");
      chk(mem_wr_data_o, 32'h77, "suspend data");
      step(CONT, 17'h0, GW_ALL, 32'h78);
      chk(32'({mem_addr_o, mem_wr_lane_o}), 32'h0DF, "continue write");
      step(SUSP, 17'h0, RD_W, 32'h0);
      chk(32'({mem_addr_o, mem_rd_o, mem_wr_lane_o}), 32'h1B0, "resampled read");
   endtask

   task automatic t_pass_through;
      do_reset(1'b1);
      step(BEG_WC, 17'h3, GW_ALL, 32'h5A5A1234);
      step(BEG_RD, 17'h3, RD_W, 32'h0);
      chk(32'(data_oe_o), 32'h0, "drive after write");
      csel = 3'b110;
      step(BEG_WC, 17'h0, RD_W, 32'h0);
      chk(data_o, 32'h5A5A1234, "pass-through data");
      chk(32'(selected_o), 32'h0, "deselect");
      csel = 3'b010;
      step(CONT, 17'h0, RD_W, 32'h0);
      chk(32'(data_oe_o), 32'h0, "no carry over");
      step(CONT, 17'h0, GW_ALL, 32'h0);
      chk(32'({selected_o, mem_rd_o, mem_wr_lane_o}), 32'h0, "stays idle");
      step(BEG_RD, 17'h4, RD_W, 32'h0);
      step(SUSP, 17'h0, RD_W, 32'h0);
      oe_n = 1'b1;
      #1 chk(32'(data_oe_o), 32'h0, "enable high");
      oe_n = 1'b0;
      #1 chk(32'(data_oe_o), 32'h1, "enable low");
   endtask

   // each non-selecting enable mix with the first enable low, with either strobe, closes an open burst
   task automatic t_select_mix;
      logic [2:0] mix [3] = '{3'b000, 3'b011, 3'b001};
      do_reset(1'b0);
      for (int i = 0; i < 6; i++) begin
         step(BEG_RD, 17'h4, RD_W, 32'h0);
         csel = mix[i % 3];
         step((i < 3) ? BEG_RD : BEG_WC, 17'h6, GW_ALL, 32'h0);
         csel = 3'b010;
         chk(32'({selected_o, mem_rd_o, mem_wr_lane_o}), 32'h0, "unselected");
      end
   endtask

   task automatic t_sleep;
      do_reset(1'b1);
      step(BEG_RD, 17'h4, RD_W, 32'h0);
      sleep = 1'b1;
      step(CONT, 17'h0, RD_W, 32'h0);
      chk(32'({asleep_o, mem_rd_o}), 32'h2, "asleep");
      sleep = 1'b0;
      step(CONT, 17'h0, RD_W, 32'h0);
      chk(32'({asleep_o, mem_rd_o, mem_addr_o}), 32'h20005, "awake keeps position");
   endtask

   // a low clock enable must freeze the burst even while strobes ask for a write
   task automatic t_freeze;
      do_reset(1'b0);
      step(BEG_RD, 17'h2, RD_W, 32'h0);
      clk_en_i = 1'b0;
      step(CONT, 17'h1FFFF, GW_ALL, 32'h0);
      chk(32'({mem_addr_o, mem_rd_o, mem_wr_lane_o}), 32'h50, "frozen access");
      chk(32'(data_oe_o), 32'h0, "frozen bus");
      clk_en_i = 1'b1;
      step(CONT, 17'h0, RD_W, 32'h0);
      chk(32'({mem_addr_o, mem_rd_o, mem_wr_lane_o}), 32'h70, "after freeze");
      chk(data_o, 32'hC0DE0002, "read after freeze");
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      {rst_n_i, clk_en_i, ps_n, ac_n, adv_n, gw_n, bwe_n} = 7'h3F;
      {order, sleep, oe_n, csel, lanes} = {3'b100, 3'b010, 4'hF};
      addr_i = '0;
      data_i = '0;
      @(negedge clock_i);
      t_read_burst(1'b1);
      t_read_burst(1'b0);
      t_write_lanes;
      t_pass_through;
      t_select_mix;
      t_sleep;
      t_freeze;
      print_verdict;
   end

   initial begin
      #(25ns * 2000);
      err_count++;
      print_verdict;
   end
endmodule
